// ### verilog/fault_cascade_defs.vh
// offsets, field positions, reset values and timing for fault cascade block
`ifndef FAULT_CASCADE_DEFS_VH
`define FAULT_CASCADE_DEFS_VH
`define REG_CTRL     8'h00
`define REG_STATUS   8'h04
`define REG_RUNTIME  8'h08
`define REG_RSTCNT   8'h0C
`define REG_FMAP0    8'h10
`define REG_FMAP3    8'h1C
`define REG_RFAULT   8'h20
`define REG_RWARN    8'h24
`define REG_LIVE     8'h28
`define REG_SEL      8'h30
`define REG_LATEST   8'h34
`define REG_PEAK     8'h38
`define REG_LOGINFO  8'h40
`define REG_LOGTIME  8'h44
`define REG_LOGVOLT  8'h48
`define REG_BBRAIL   8'h50
`define REG_BBWARN   8'h54
`define REG_BBPINS   8'h58
`define CTRL_SLAVE   0
`define CTRL_BB_CLR  1
`define CTRL_RST_CLR 2
`define CTRL_PEN_LO  4
`define CTRL_RESET   32'h0000_0000
`define FT_RAIL      2'h1
`define FT_BUS       2'h2
`define NVM_LOG      8'h00
`define NVM_PEAK     8'h40
`define NVM_RSTCNT   8'h60
`define NVM_RUNTIME  8'h61
`define NVM_BB       8'h70
`define SYS_CLK_HZ   50000000
`define SYNC_HZ      5000
`define PEAK_WIN_S   30
`define BB_WRITE_MS  4
`endif

// ### verilog/fault_cascade_and_logging.v
// fault bus cascade, sync time base and nonvolatile fault logging
// Overview of operation
// - up to four general inputs may be enabled as fault pins, each on a bus
// - with no fault, an enabled fault pin stays input and just watches its bus
// - a fault on a mapped rail drives that pin low, pulling the bus down
// - once that fault clears, the pin is released back to input only
// - each of 24 rails maps to any set of fault pins, or none
// - all devices treat a low bus as the same fault condition
// - sync master drives a continuous 5 kHz clock on the sync pin
// - all devices act on fault events on the shared sync time base
// - a control bit makes the device a slave to an external sync clock
// - latest readings of 24 inputs are kept and readable by the host
// - per-rail fault and warning status is kept and host readable
// - a new peak opens a 30 s window; only its highest goes to nvm
// - fault records hold rail, type, time since reset and last voltage
// - fault records are kept in nvm and readable by the host
// - a reset count lives in nvm and the host may clear it
// - on power-down the runtime clock is written to nvm
// - the host may write the runtime clock; it converts units itself
// - the first rail fault snapshots all rail and pin status to a black box
// - later faults leave the black box alone but still go to the log
// - the black box captures nothing new until the host clears it
// - once the log writer is idle, black box writing takes 4 ms
`default_nettype none
`include "fault_cascade_defs.vh"
module fault_cascade_and_logging #(
  parameter integer SYNC_HALF = `SYS_CLK_HZ / (2 * `SYNC_HZ),
  parameter integer PEAK_WIN  = `PEAK_WIN_S * `SYS_CLK_HZ,
  parameter integer BB_CYC    = `BB_WRITE_MS * (`SYS_CLK_HZ / 1000),
  parameter integer LOG_DEPTH = 8
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [23:0] rail_fault,
  input  wire [23:0] rail_warn,
  input  wire        meas_valid,
  input  wire [4:0]  meas_rail,
  input  wire [11:0] meas_value,
  input  wire        power_down,
  input  wire [3:0]  fault_pin_in,
  output reg  [3:0]  fault_pin_out,
  output reg  [3:0]  fault_pin_oe,
  output reg  [3:0]  bus_fault,
  input  wire        sync_in,
  output reg         sync_out,
  output reg         sync_oe,
  output reg         time_tick,
  input  wire [15:0] nvm_rst_count,
  input  wire [31:0] nvm_runtime,
  output reg         nvm_req,
  output reg  [7:0]  nvm_addr,
  output reg  [31:0] nvm_wdata,
  input  wire        nvm_ready
);
  localparam BB_IDLE  = 2'b00;
  localparam BB_WAIT  = 2'b01;
  localparam BB_WRITE = 2'b10;
  localparam BB_DONE  = 2'b11;

  function [4:0] first_one;
    input [23:0] m;
    integer i;
    begin
      first_one = 5'h00;
      for (i = 23; i >= 0; i = i - 1) begin
        if (m[i]) first_one = i[4:0];
      end
    end
  endfunction

  reg  [31:0] ctrl_r;
  reg  [23:0] fmap_r [0:3];
  reg  [23:0] rstat_f_r;
  reg  [23:0] rstat_w_r;
  reg  [4:0]  sel_rail_r;
  reg  [2:0]  sel_log_r;
  reg  [11:0] latest [0:23];
  reg  [11:0] peak [0:23];
  reg  [23:0] pk_valid_r;
  reg  [23:0] pk_dirty_r;
  reg  [23:0] pk_flush_r;
  reg         win_on_r;
  reg  [30:0] win_cnt_r;
  reg  [6:0]  log_rt [0:LOG_DEPTH-1];
  reg  [31:0] log_tm [0:LOG_DEPTH-1];
  reg  [11:0] log_v  [0:LOG_DEPTH-1];
  reg  [2:0]  log_ptr_r;
  reg  [7:0]  log_cnt_r;
  reg  [1:0]  log_words_r;
  reg  [2:0]  log_slot_r;
  reg  [23:0] rf_prev_r;
  reg  [23:0] lq_r;
  reg  [3:0]  bus_prev_r;
  reg  [3:0]  bq_r;
  reg  [31:0] runtime_r;
  reg  [31:0] uptime_r;
  reg  [15:0] rst_cnt_r;
  reg         rst_pend_r;
  reg         rt_pend_r;
  reg         pd_prev_r;
  reg         init_r;
  reg  [3:0]  fsy1_r;
  reg  [3:0]  fsy2_r;
  reg         ssy1_r;
  reg         ssy2_r;
  reg         ssy3_r;
  reg  [15:0] div_r;
  reg  [1:0]  bb_state_r;
  reg  [17:0] bb_cnt_r;
  reg  [1:0]  bb_words_r;
  reg  [23:0] bb_rail_r;
  reg  [23:0] bb_warn_r;
  reg  [9:0]  bb_pins_r;
  reg  [31:0] rd_nxt;
  reg         err_nxt;
  reg  [3:0]  drive_nxt;
  integer     k;
  integer     j;

  wire        slave   = ctrl_r[`CTRL_SLAVE];
  wire [3:0]  pin_en  = ctrl_r[`CTRL_PEN_LO+3:`CTRL_PEN_LO];
  wire        rd_acc  = psel & penable & ~pready;
  wire        wr_en   = psel & penable & pready & pwrite;
  wire [31:0] wmask   = {32{wr_en}} & pwdata;
  wire        wr_ctrl = wr_en & (paddr == `REG_CTRL);
  wire        bb_clr  = wr_ctrl & pwdata[`CTRL_BB_CLR];
  wire        rc_clr  = wr_ctrl & pwdata[`CTRL_RST_CLR];
  wire        div_end = (div_r == SYNC_HALF - 1);
  wire        tick_nxt = slave ? (ssy2_r & ~ssy3_r)
                               : (div_end & ~sync_out);
  wire [23:0] rf_new  = rail_fault & ~rf_prev_r;
  wire [3:0]  bus_new = bus_fault & ~bus_prev_r;
  wire        log_go  = (log_words_r == 2'd0) & ((|lq_r) | (|bq_r));
  wire        q_bus   = ~(|lq_r);
  wire [4:0]  q_idx   = q_bus ? first_one({20'h0, bq_r}) : first_one(lq_r);
  wire [4:0]  fl_idx  = first_one(pk_flush_r);
  wire        nvm_free = ~nvm_req | nvm_ready;
  wire        bb_first = (bb_state_r == BB_IDLE) | bb_clr;

  // fault pin drive, per-rail pin mapping
  always @* begin
    for (k = 0; k < 4; k = k + 1) begin
      drive_nxt[k] = pin_en[k] & (|(rail_fault & fmap_r[k]));
    end
  end

  // synchronisers and sync time base
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsy1_r        <= 4'hF;
      fsy2_r        <= 4'hF;
      ssy1_r        <= 1'b0;
      ssy2_r        <= 1'b0;
      ssy3_r        <= 1'b0;
      div_r         <= 16'h0000;
      sync_out      <= 1'b0;
      sync_oe       <= 1'b0;
      time_tick     <= 1'b0;
      fault_pin_out <= 4'h0;
      fault_pin_oe  <= 4'h0;
      bus_fault     <= 4'h0;
      bus_prev_r    <= 4'h0;
    end else begin
      fsy1_r     <= fault_pin_in;
      fsy2_r     <= fsy1_r;
      ssy1_r     <= sync_in;
      ssy2_r     <= ssy1_r;
      ssy3_r     <= ssy2_r;
      sync_oe    <= ~slave;
      if (div_end) begin
        div_r    <= 16'h0000;
        sync_out <= slave ? 1'b0 : ~sync_out;
      end else begin
        div_r    <= div_r + 16'h0001;
      end
      time_tick     <= tick_nxt;
      fault_pin_out <= 4'h0;
      fault_pin_oe  <= drive_nxt;
      if (time_tick) begin
        bus_fault <= pin_en & ~fsy2_r;
      end
      bus_prev_r <= bus_fault;
    end
  end

  // readings, peaks and peak window
  always @(posedge pclk) begin
    if (meas_valid && meas_rail < 5'd24) begin
      latest[meas_rail] <= meas_value;
      if (!pk_valid_r[meas_rail] || meas_value > peak[meas_rail]) begin
        peak[meas_rail] <= meas_value;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pk_valid_r <= 24'h000000;
      pk_dirty_r <= 24'h000000;
      win_on_r   <= 1'b0;
      win_cnt_r  <= 31'h00000000;
    end else begin
      if (win_on_r && win_cnt_r == 31'h00000000) begin
        win_on_r   <= 1'b0;
        pk_dirty_r <= 24'h000000;
      end else if (win_on_r) begin
        win_cnt_r  <= win_cnt_r - 31'h00000001;
      end
      if (meas_valid && meas_rail < 5'd24 && (!pk_valid_r[meas_rail]
          || meas_value > peak[meas_rail])) begin
        pk_valid_r[meas_rail] <= 1'b1;
        pk_dirty_r[meas_rail] <= 1'b1;
        if (!win_on_r || win_cnt_r == 31'h00000000) begin
          win_on_r  <= 1'b1;
          win_cnt_r <= PEAK_WIN[30:0] - 31'h00000001;
        end
      end
    end
  end

  // fault log, black box, counters, nvm writes
  always @(posedge pclk) begin
    if (log_go) begin
      log_rt[log_ptr_r] <= {q_idx, q_bus ? `FT_BUS : `FT_RAIL};
      log_tm[log_ptr_r] <= uptime_r;
      log_v[log_ptr_r]  <= q_bus ? 12'h000 : latest[q_idx];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_r      <= 1'b1;
      rf_prev_r   <= 24'h000000;
      lq_r        <= 24'h000000;
      bq_r        <= 4'h0;
      log_ptr_r   <= 3'h0;
      log_cnt_r   <= 8'h00;
      log_words_r <= 2'd0;
      log_slot_r  <= 3'h0;
      runtime_r   <= 32'h00000000;
      uptime_r    <= 32'h00000000;
      rst_cnt_r   <= 16'h0000;
      rst_pend_r  <= 1'b0;
      rt_pend_r   <= 1'b0;
      pd_prev_r   <= 1'b0;
      pk_flush_r  <= 24'h000000;
      bb_state_r  <= BB_IDLE;
      bb_cnt_r    <= 18'h00000;
      bb_words_r  <= 2'd0;
      bb_rail_r   <= 24'h000000;
      bb_warn_r   <= 24'h000000;
      bb_pins_r   <= 10'h000;
      nvm_req     <= 1'b0;
      nvm_addr    <= 8'h00;
      nvm_wdata   <= 32'h00000000;
    end else begin
      rf_prev_r <= rail_fault;
      pd_prev_r <= power_down;
      if (time_tick) begin
        runtime_r <= runtime_r + 32'h00000001;
        uptime_r  <= uptime_r + 32'h00000001;
      end
      if (wr_en && paddr == `REG_RUNTIME) begin
        runtime_r <= pwdata;
      end
      if (init_r) begin
        init_r     <= 1'b0;
        runtime_r  <= nvm_runtime;
        rst_cnt_r  <= nvm_rst_count + 16'h0001;
      end
      // log queue: one record at a time, taken only when the writer is idle
      if (log_go) begin
        log_ptr_r   <= log_ptr_r + 3'h1;
        log_slot_r  <= log_ptr_r;
        log_words_r <= 2'd3;
        if (log_cnt_r != 8'hFF) log_cnt_r <= log_cnt_r + 8'h01;
        if (q_bus) bq_r[q_idx[1:0]] <= 1'b0;
        else lq_r[q_idx] <= 1'b0;
      end
      lq_r <= (log_go && !q_bus) ? ((lq_r & ~(24'h1 << q_idx)) | rf_new)
                                 : (lq_r | rf_new);
      bq_r <= (log_go && q_bus) ? ((bq_r & ~(4'h1 << q_idx[1:0])) | bus_new)
                                : (bq_r | bus_new);
      if (win_on_r && win_cnt_r == 31'h00000000) begin
        pk_flush_r <= pk_flush_r | pk_dirty_r;
      end
      // black box sequence
      case (bb_state_r)
        BB_IDLE: begin
        end
        BB_WAIT: begin
          if (log_words_r == 2'd0 && nvm_free) begin
            bb_state_r <= BB_WRITE;
            bb_cnt_r   <= BB_CYC[17:0] - 18'h00001;
          end
        end
        BB_WRITE: begin
          if (bb_cnt_r == 18'h00000) begin
            bb_state_r <= BB_DONE;
            bb_words_r <= 2'd3;
          end else begin
            bb_cnt_r <= bb_cnt_r - 18'h00001;
          end
        end
        BB_DONE: begin
        end
        default: bb_state_r <= BB_IDLE;
      endcase
      if (bb_clr) begin
        bb_state_r <= BB_IDLE;
        bb_words_r <= 2'd0;
      end
      if (bb_first && (|rf_new)) begin
        bb_state_r <= BB_WAIT;
        bb_rail_r  <= rail_fault;
        bb_warn_r  <= rail_warn;
        bb_pins_r  <= {sync_out, ssy2_r, fsy2_r, drive_nxt};
      end
      // nvm write arbiter: runtime, log, reset count, peaks, black box
      if (nvm_req && nvm_ready) nvm_req <= 1'b0;
      if (nvm_free) begin
        if (rt_pend_r) begin
          nvm_req   <= 1'b1;
          nvm_addr  <= `NVM_RUNTIME;
          nvm_wdata <= runtime_r;
          rt_pend_r <= 1'b0;
        end else if (log_words_r != 2'd0 && !log_go) begin
          nvm_req     <= 1'b1;
          nvm_addr    <= `NVM_LOG + {3'h0, log_slot_r, 2'b00}
                         + {6'h00, 2'd3 - log_words_r};
          nvm_wdata   <= (log_words_r == 2'd3) ?
                           {25'h0, log_rt[log_slot_r]} :
                         (log_words_r == 2'd2) ? log_tm[log_slot_r] :
                           {20'h0, log_v[log_slot_r]};
          log_words_r <= log_words_r - 2'd1;
        end else if (rst_pend_r) begin
          nvm_req    <= 1'b1;
          nvm_addr   <= `NVM_RSTCNT;
          nvm_wdata  <= {16'h0000, rst_cnt_r};
          rst_pend_r <= 1'b0;
        end else if (|pk_flush_r) begin
          nvm_req    <= 1'b1;
          nvm_addr   <= `NVM_PEAK + {3'h0, fl_idx};
          nvm_wdata  <= {20'h0, peak[fl_idx]};
          pk_flush_r[fl_idx] <= 1'b0;
        end else if (bb_words_r != 2'd0) begin
          nvm_req    <= 1'b1;
          nvm_addr   <= `NVM_BB + {6'h00, 2'd3 - bb_words_r};
          nvm_wdata  <= (bb_words_r == 2'd3) ? {8'h00, bb_rail_r} :
                        (bb_words_r == 2'd2) ? {8'h00, bb_warn_r} :
                        {22'h0, bb_pins_r};
          bb_words_r <= bb_words_r - 2'd1;
        end
      end
      if (power_down && !pd_prev_r) rt_pend_r <= 1'b1;
      if (win_on_r && win_cnt_r == 31'h00000000 && pk_dirty_r[fl_idx]) begin
        pk_flush_r[fl_idx] <= 1'b1;
      end
      if (init_r) rst_pend_r <= 1'b1;
      if (rc_clr) begin
        rst_cnt_r  <= 16'h0000;
        rst_pend_r <= 1'b1;
      end
    end
  end

  // apb register file
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `CTRL_RESET;
      for (j = 0; j < 4; j = j + 1) fmap_r[j] <= 24'h000000;
      rstat_f_r  <= 24'h000000;
      rstat_w_r  <= 24'h000000;
      sel_rail_r <= 5'h00;
      sel_log_r  <= 3'h0;
      prdata     <= 32'h00000000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      pready  <= rd_acc;
      pslverr <= rd_acc & err_nxt;
      prdata  <= rd_acc ? rd_nxt : 32'h00000000;
      if (wr_ctrl) begin
        ctrl_r <= {24'h0, pwdata[7:4], 3'h0, pwdata[0]};
      end
      if (wr_en && paddr >= `REG_FMAP0 && paddr <= `REG_FMAP3
          && paddr[1:0] == 2'b00) begin
        fmap_r[paddr[3:2]] <= pwdata[23:0];
      end
      if (wr_en && paddr == `REG_SEL) begin
        sel_rail_r <= pwdata[4:0];
        sel_log_r  <= pwdata[10:8];
      end
      rstat_f_r <= (rstat_f_r & ~((paddr == `REG_RFAULT) ?
                   wmask[23:0] : 24'h0)) | rail_fault;
      rstat_w_r <= (rstat_w_r & ~((paddr == `REG_RWARN) ?
                   wmask[23:0] : 24'h0)) | rail_warn;
    end
  end

  always @* begin
    rd_nxt  = 32'h00000000;
    err_nxt = 1'b0;
    case (paddr)
      `REG_CTRL:    rd_nxt = ctrl_r;
      `REG_STATUS:  rd_nxt = {22'h0, bb_state_r, bus_fault, fault_pin_oe};
      `REG_RUNTIME: rd_nxt = runtime_r;
      `REG_RSTCNT:  rd_nxt = {16'h0, rst_cnt_r};
      8'h10, 8'h14, 8'h18, `REG_FMAP3: rd_nxt = {8'h0, fmap_r[paddr[3:2]]};
      `REG_RFAULT:  rd_nxt = {8'h0, rstat_f_r};
      `REG_RWARN:   rd_nxt = {8'h0, rstat_w_r};
      `REG_LIVE:    rd_nxt = {8'h0, rail_fault};
      `REG_SEL:     rd_nxt = {21'h0, sel_log_r, 3'h0, sel_rail_r};
      `REG_LATEST:  rd_nxt = (sel_rail_r < 5'd24) ?
                      {20'h0, latest[sel_rail_r]} : 32'h0;
      `REG_PEAK:    rd_nxt = (sel_rail_r < 5'd24) ?
                      {20'h0, peak[sel_rail_r]} : 32'h0;
      `REG_LOGINFO: rd_nxt = {16'h0, log_cnt_r, 1'b0,
                      log_rt[sel_log_r]};
      `REG_LOGTIME: rd_nxt = log_tm[sel_log_r];
      `REG_LOGVOLT: rd_nxt = {20'h0, log_v[sel_log_r]};
      `REG_BBRAIL:  rd_nxt = {8'h0, bb_rail_r};
      `REG_BBWARN:  rd_nxt = {8'h0, bb_warn_r};
      `REG_BBPINS:  rd_nxt = {22'h0, bb_pins_r};
      default:      err_nxt = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// ### tb/fault_cascade_chk.sv
// assertion checker for the fault cascade and logging block
`default_nettype none
module fault_cascade_chk #(
  parameter integer SYNC_HALF = 5000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [23:0] rail_fault,
  input wire logic [3:0]  fault_pin_out,
  input wire logic [3:0]  fault_pin_oe,
  input wire logic [3:0]  bus_fault,
  input wire logic        sync_in,
  input wire logic        sync_out,
  input wire logic        sync_oe,
  input wire logic        time_tick,
  input wire logic        nvm_req,
  input wire logic [7:0]  nvm_addr,
  input wire logic [31:0] nvm_wdata,
  input wire logic        nvm_ready
);
  logic [31:0] half_cnt;
  logic        prev_out;
  logic        seen;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since the last sync output edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt <= 32'h0000_0000;
      prev_out <= 1'b0;
      seen     <= 1'b0;
    end else begin
      prev_out <= sync_out;
      if (sync_out != prev_out) begin
        half_cnt <= 32'h0000_0000;
        seen     <= sync_oe;
      end else begin
        half_cnt <= half_cnt + 32'h0000_0001;
        seen     <= seen & sync_oe;
      end
    end
  end
  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready held longer than one cycle");
  property p_pready_cause;
    pready |-> $past(psel && penable) && psel && penable;
  endproperty
  a_pready_cause: assert property (p_pready_cause)
    else $error("pready without an access phase");
  property p_slverr;
    pslverr |-> pready;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("pslverr outside pready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero while idle");
  property p_pin_low;
    fault_pin_out == 4'h0;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("fault pin driven high");
  property p_oe_cause;
    $rose(|fault_pin_oe) |-> $past(|rail_fault);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("fault pin driven without rail fault");
  property p_sync_half;
    sync_oe && seen && (sync_out != prev_out) |-> half_cnt == SYNC_HALF - 1;
  endproperty
  a_sync_half: assert property (p_sync_half)
    else $error("sync half period wrong");
  property p_tick_pulse;
    time_tick |=> !time_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("time tick longer than one cycle");
  property p_slave_tick;
    !sync_oe && $rose(sync_in) |-> ##[2:5] time_tick;
  endproperty
  a_slave_tick: assert property (p_slave_tick)
    else $error("no time tick after sync edge");
  property p_nvm_hold;
    nvm_req && !nvm_ready |=> nvm_req && $stable(nvm_addr)
      && $stable(nvm_wdata);
  endproperty
  a_nvm_hold: assert property (p_nvm_hold)
    else $error("nvm request changed before taken");
  property p_bus_tick;
    $changed(bus_fault) |-> time_tick || $past(time_tick);
  endproperty
  a_bus_tick: assert property (p_bus_tick)
    else $error("bus fault changed off the time base");
endmodule
bind fault_cascade_and_logging fault_cascade_chk #(
  .SYNC_HALF(SYNC_HALF)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rail_fault(rail_fault), .fault_pin_out(fault_pin_out),
  .fault_pin_oe(fault_pin_oe), .bus_fault(bus_fault), .sync_in(sync_in),
  .sync_out(sync_out), .sync_oe(sync_oe), .time_tick(time_tick),
  .nvm_req(nvm_req), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
  .nvm_ready(nvm_ready)
);
`default_nettype wire

// ### tb/peer_seq.sv
// peer sequencers on the shared fault buses and sync wire
`default_nettype none
module peer_seq (
  input  wire logic       sync_en,
  input  wire logic [3:0] pull,
  input  wire logic [3:0] dut_oe,
  output wire logic [3:0] bus,
  output var  logic       sync_clk,
  output wire logic [3:0] seen_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  // open-drain buses with pull-ups
  assign bus = ~(pull | dut_oe);
  assign seen_fault = ~bus;
  // master clock while sync_en is high, held low otherwise, 160 ns period
  initial begin
    sync_clk = 1'b0;
    #37;
    forever begin
      #80;
      sync_clk = sync_en ? ~sync_clk : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_fault_cascade_and_logging.sv
// self-checking bench for the fault cascade and logging block
`default_nettype none
`include "fault_cascade_defs.vh"
module tb_fault_cascade_and_logging;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, nvm_addr;
  logic [31:0] pwdata, prdata, nvm_wdata, nvm_runtime, r;
  logic [23:0] rail_fault, rail_warn;
  logic        meas_valid, power_down, sync_out, sync_oe, time_tick;
  logic [4:0]  meas_rail;
  logic [11:0] meas_value;
  logic [3:0]  fault_pin_in, fault_pin_out, fault_pin_oe, bus_fault;
  logic [3:0]  pull, peer_seen;
  logic        sync_line, peer_clk, sync_en, nvm_req, nvm_ready, e;
  logic [15:0] nvm_rst_count;
  logic [31:0] nvm_mem [0:255];
  int          n_errors, n_checks, cnt;
  assign sync_line = sync_oe ? sync_out : peer_clk;
  fault_cascade_and_logging #(
    .SYNC_HALF(4), .PEAK_WIN(50), .BB_CYC(20), .LOG_DEPTH(8)
  ) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rail_fault(rail_fault),
    .rail_warn(rail_warn), .meas_valid(meas_valid), .meas_rail(meas_rail),
    .meas_value(meas_value), .power_down(power_down),
    .fault_pin_in(fault_pin_in), .fault_pin_out(fault_pin_out),
    .fault_pin_oe(fault_pin_oe), .bus_fault(bus_fault), .sync_in(sync_line),
    .sync_out(sync_out), .sync_oe(sync_oe), .time_tick(time_tick),
    .nvm_rst_count(nvm_rst_count), .nvm_runtime(nvm_runtime),
    .nvm_req(nvm_req), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
    .nvm_ready(nvm_ready)
  );
  peer_seq peer (
    .sync_en(sync_en), .pull(pull), .dut_oe(fault_pin_oe),
    .bus(fault_pin_in), .sync_clk(peer_clk), .seen_fault(peer_seen)
  );
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // nonvolatile store, ready every other cycle
  always @(posedge pclk) begin
    nvm_ready <= ~nvm_ready;
    if (nvm_req && nvm_ready)
      nvm_mem[nvm_addr] <= nvm_wdata;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic meas(input logic [4:0] rl, input logic [11:0] v);
    @(posedge pclk);
    meas_valid <= 1'b1;
    meas_rail <= rl;
    meas_value <= v;
    @(posedge pclk);
    meas_valid <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100us;
    n_errors++;
    conclude();
  end
  initial begin
    {presetn, psel, penable, pwrite, meas_valid, power_down} = 6'h00;
    {paddr, pwdata, rail_fault, rail_warn} = 0;
    {meas_rail, meas_value, pull, sync_en, nvm_ready} = 0;
    nvm_rst_count = 16'h0005;
    nvm_runtime = 32'h0000_0100;
    cyc(3);
    presetn <= 1'b1;
    cyc(2);
    apb(0, `REG_RSTCNT, 0);
    chk("rstcnt", r, 32'h0000_0006);
    apb(0, 8'hFC, 0);
    chk("unmapped", {e, r[30:0]}, 32'h8000_0000);
    cyc(20);
    chk("nvm rstcnt", nvm_mem[`NVM_RSTCNT], 32'h0000_0006);
    chk("master", sync_oe, 1'b1);
    rail_warn <= 24'h000004;
    meas(3, 12'h5A5);
    meas(5, 12'h100);
    meas(5, 12'h300);
    meas(5, 12'h200);
    apb(1, `REG_SEL, 32'h0000_0005);
    apb(0, `REG_LATEST, 0);
    chk("latest", r, 32'h0000_0200);
    apb(0, `REG_PEAK, 0);
    chk("peak", r, 32'h0000_0300);
    cyc(100);
    chk("nvm peak", nvm_mem[`NVM_PEAK + 8'h05], 32'h0000_0300);
    apb(1, `REG_CTRL, 32'h0000_0070);
    apb(1, `REG_FMAP0, 32'h0000_0008);
    apb(1, 8'h14, 32'h0000_0028);
    apb(1, 8'h18, 32'h0000_0000);
    apb(1, `REG_FMAP3, 32'h0000_0008);
    chk("oe idle", fault_pin_oe, 4'h0);
    rail_fault <= 24'h000008;
    cyc(6);
    chk("oe fault", fault_pin_oe, 4'h3);
    chk("peer sees", peer_seen, 4'h3);
    apb(0, `REG_STATUS, 0);
    chk("status oe", r & 32'hF, 32'h3);
    rail_fault <= 24'h000000;
    cyc(6);
    chk("oe released", fault_pin_oe, 4'h0);
    apb(0, `REG_RFAULT, 0);
    chk("sticky", r & 32'h8, 32'h8);
    apb(1, `REG_RFAULT, 32'h0000_0008);
    apb(0, `REG_RFAULT, 0);
    chk("sticky clr", r & 32'h8, 32'h0);
    apb(0, `REG_RWARN, 0);
    chk("warn", r & 32'h4, 32'h4);
    apb(1, `REG_SEL, 32'h0000_0000);
    apb(0, `REG_LOGINFO, 0);
    chk("log info", r & 32'h7F, {25'h0, 5'd3, `FT_RAIL});
    apb(0, `REG_LOGVOLT, 0);
    chk("log volt", r, 32'h0000_05A5);
    apb(0, `REG_BBRAIL, 0);
    chk("bb first", r, 32'h0000_0008);
    rail_fault <= 24'h000080;
    cyc(3);
    rail_fault <= 24'h000000;
    cyc(60);
    apb(0, `REG_BBRAIL, 0);
    chk("bb kept", r, 32'h0000_0008);
    apb(0, `REG_LOGINFO, 0);
    chk("log grew", 32'(r[15:8] >= 8'h02), 32'h1);
    apb(1, `REG_CTRL, 32'h0000_0072);
    cyc(10);
    rail_fault <= 24'h000200;
    cyc(3);
    rail_fault <= 24'h000000;
    cyc(80);
    apb(0, `REG_BBRAIL, 0);
    chk("bb rearm", r, 32'h0000_0200);
    chk("nvm bb", nvm_mem[`NVM_BB], 32'h0000_0200);
    pull <= 4'hC;
    cyc(40);
    chk("bus fault", bus_fault, 4'h4);
    apb(0, `REG_STATUS, 0);
    chk("status bus", r & 32'hF0, 32'h40);
    pull <= 4'h0;
    cyc(40);
    chk("bus clear", bus_fault, 4'h0);
    apb(1, `REG_RUNTIME, 32'h0000_1234);
    apb(0, `REG_RUNTIME, 0);
    chk("runtime", 32'(r - 32'h1234 < 32'd4), 32'h1);
    apb(1, `REG_CTRL, 32'h0000_0071);
    sync_en <= 1'b1;
    cyc(10);
    chk("slave", sync_oe, 1'b0);
    cnt = 0;
    repeat (400) begin
      @(posedge pclk);
      if (time_tick === 1'b1) cnt++;
    end
    chk("ticks", 32'(cnt >= 49 && cnt <= 51), 32'h1);
    power_down <= 1'b1;
    sync_en <= 1'b0;
    cyc(40);
    chk("nvm run", 32'(nvm_mem[`NVM_RUNTIME] - 32'h1234 < 32'd100),
        32'h1);
    apb(1, `REG_CTRL, 32'h0000_0074);
    apb(0, `REG_RSTCNT, 0);
    chk("rstcnt clr", r, 32'h0000_0000);
    conclude();
  end
endmodule
`default_nettype wire
